/* hw/io_pin_config_pkg.sv */
// constants, register map and shared types of the pin configuration and remap block
package io_pin_config_pkg;

  // bus and field widths
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned SEL_W     = 6;
  localparam int unsigned SRC_COUNT = 64;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned MAX_WORDS = 8;

  // register offsets (word index on the register port)
  localparam logic [7:0] ANSEL_ADDR    = 8'h00;
  localparam logic [7:0] ANALOG_CONFIG_ADDR    = 8'h01;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h02;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h03;
  localparam logic [7:0] PORTG_ADDR    = 8'h04;
  localparam logic [7:0] CN_EN_BASE    = 8'h10;
  localparam logic [7:0] PULLUP_BASE   = 8'h18;
  localparam logic [7:0] PULLDN_BASE   = 8'h20;
  localparam logic [7:0] CN_LVL_BASE   = 8'h28;
  localparam logic [7:0] SEL_BASE      = 8'h30;

  // field positions
  localparam int unsigned VBG_BIT     = 2;
  localparam int unsigned IRQ_CN_BIT  = 0;
  localparam int unsigned SEL_LO_POS  = 0;
  localparam int unsigned SEL_HI_POS  = 8;

  // implemented analog-select bits; they come out of reset set
  localparam logic [15:0] ANSEL_MASK_FULL = 16'h83C0;
  localparam logic [15:0] ANSEL_MASK_64   = 16'h03C0;

  // cycles the change detector waits after reset before it trusts its levels
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  // selector codes
  localparam logic [5:0] SEL_NULL = 6'h00;

  // one register port access, carried as a unit
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } bus_req_type;

  // true when a selector code names a peripheral output; all else acts as null
  function automatic logic code_routable(input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    case (code)
      6'h01, 6'h02, 6'h24, 6'h25:                 hit = 1'b1;
      6'h03, 6'h04, 6'h05, 6'h06:                 hit = 1'b1;
      6'h1C, 6'h1D, 6'h1E, 6'h1F:                 hit = 1'b1;
      6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C:   hit = 1'b1;
      6'h12, 6'h13, 6'h14, 6'h15:                 hit = 1'b1;
      6'h16, 6'h17, 6'h18, 6'h19, 6'h23:          hit = 1'b1;
      default:                                    hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

/* hw/cn_pin_sync.sv */
// pin synchroniser with stable-level capture and change detection
`timescale 1ns/1ps

module cn_pin_sync #(
  parameter int unsigned WIDTH = 82
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // raw pins and per-pin enables
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] enable_i,
  // results
  output logic [WIDTH-1:0]      level_o,
  output logic                  change_o,
  output logic                  wake_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("cn_pin_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] prev;
    logic [2:0]       settle;
    logic             armed;
  } sync_state_type;

  sync_state_type q;
  sync_state_type next_q;
  logic [WIDTH-1:0] agree;

  // s1 feeds only s2; a level counts once s2 and s3 agree
  always_comb begin
    next_q       = q;
    agree        = ~(q.s2 ^ q.s3);
    next_q.s1    = pin_i;
    next_q.s2    = q.s1;
    next_q.s3    = q.s2;
    next_q.level = (agree & q.s3) | (~agree & q.level);
    next_q.prev  = q.level;
    // hold off detection until the levels reflect real pins, not reset zeros
    if (!q.armed) begin
      if (q.settle == io_pin_config_pkg::SETTLE_CYCLES) begin
        next_q.armed = 1'b1;
      end else begin
        next_q.settle = q.settle + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level_o  = q.level;
  // compare the fresh stable level with the one captured a cycle before [R16] [R4]
  assign change_o = q.armed & (|(enable_i & (q.level ^ q.prev)));
  // clockless path: raw pins against the frozen captured level, no edge needed [R2]
  assign wake_o   = q.armed & (|(enable_i & (pin_i ^ q.level)));

endmodule

/* hw/io_pin_config_remap.sv */
// pin configuration: analog select, change notification, weak pulls and output remap
`timescale 1ns/1ps

// What this block does
// R1: an enabled pin changing state raises the change interrupt request to the processor.
// R2: a pin change is still seen while the clock is stopped, through a clockless compare.
// R3: up to 82 change inputs are supported, the count set by a parameter.
// R4: each change input has its own enable, and only enabled pins can raise the request.
// R5: each change pin has its own weak pull-up and weak pull-down enable bit.
// R6: software should switch the pull-up off on any pin it uses as a digital output.
// R7: port G pins 15 and 9 to 6 go analog with their digital read forced off when selected.
// R8: the pin 15 analog select is absent and reads zero in the 64-pin package.
// R9: bit 2 of the analog configuration register enables the half band-gap reference.
// R10: output remapping is organised per pin, each pin owning its selector.
// R11: each output selector register carries two 6-bit fields, one per pin.
// R12: selector code zero leaves the pin disconnected from all remappable outputs.
// R13: the listed non-zero codes route comparators, UARTs, SPIs and compare channels.
// R14: reset puts every remappable pin selector at the null code.
// R15: unassigned selector codes behave like the null code.
// R16: each enabled pin's stable level is compared with its last one to set a shared flag.
module io_pin_config_remap #(
  parameter int unsigned CN_PINS = 82,
  parameter int unsigned RP_PINS = 32,
  parameter bit          PKG_64  = 1'b0
) (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  // register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [15:0]           reg_rdata_o,
  // change notification pins and pulls
  input  wire logic [CN_PINS-1:0]    cn_pin_i,
  output logic      [CN_PINS-1:0]    weak_pullup_o,
  output logic      [CN_PINS-1:0]    weak_pulldown_o,
  output logic                       cn_wake_o,
  output logic                       cn_irq_o,
  // port g analog select
  input  wire logic [15:0]           portg_pin_i,
  output logic      [15:0]           portg_read_o,
  output logic      [15:0]           portg_analog_o,
  output logic                       half_bandgap_ref_enable_o,
  // output remap
  input  wire logic [63:0]           periph_out_i,
  output logic      [RP_PINS-1:0]    remappable_pin_o,
  output logic      [RP_PINS-1:0]    remappable_pin_oe_n_o
);

  localparam int unsigned CN_WORDS = (CN_PINS + 15) / 16;
  localparam int unsigned CN_BITS  = CN_WORDS * 16;
  localparam int unsigned SEL_REGS = RP_PINS / 2;
  localparam logic [CN_BITS-1:0] CN_MASK = {CN_BITS{1'b1}} >> (CN_BITS - CN_PINS);
  localparam logic [15:0] ANSEL_IMPL = PKG_64 ? io_pin_config_pkg::ANSEL_MASK_64
                                              : io_pin_config_pkg::ANSEL_MASK_FULL;

  // refuse sizes that overrun the register windows
  if (CN_PINS < 1 || CN_PINS > 82) begin : g_bad_cn
    $error("io_pin_config_remap: CN_PINS must be 1 to 82");
  end
  if (RP_PINS < 2 || RP_PINS > 32 || (RP_PINS % 2) != 0) begin : g_bad_rp
    $error("io_pin_config_remap: RP_PINS must be even, 2 to 32");
  end

  typedef struct packed {
    logic [15:0]              ansel;
    logic                     vbg;
    logic                     stat;
    logic                     mask;
    logic                     irq;
    logic [CN_BITS-1:0]       cn_en;
    logic [CN_BITS-1:0]       pu;
    logic [CN_BITS-1:0]       pd;
    logic [RP_PINS-1:0][5:0]  sel;
    logic [RP_PINS-1:0]       rp_out;
    logic [RP_PINS-1:0]       rp_oe_n;
    logic [15:0]              portg_read;
    logic [15:0]              rdata;
  } cfg_state_type;

  // analog-select bits come up set; pins float undriven until software remaps
  localparam cfg_state_type RESET_STATE = '{
    ansel:   ANSEL_IMPL,
    rp_oe_n: {RP_PINS{1'b1}},
    default: '0
  };

  cfg_state_type                 q;
  cfg_state_type                 next_q;
  io_pin_config_pkg::bus_req_type req;
  logic [CN_PINS-1:0]            cn_level;
  logic [CN_BITS-1:0]            cn_level_wide;
  logic [15:0]                   portg_level;
  logic                          cn_change;
  logic                          cn_wake;
  logic                          stat_clear;

  // pack the register port into one carrier
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  // change notification pins: synchronise, capture and compare
  cn_pin_sync #(
    .WIDTH (CN_PINS)
  ) u_cn_sync (
    .mclk_i   (mclk_i),
    .rstn_i   (rstn_i),
    .pin_i    (cn_pin_i),
    .enable_i (q.cn_en[CN_PINS-1:0]),
    .level_o  (cn_level),
    .change_o (cn_change),
    .wake_o   (cn_wake)
  );

  // port g pins only need the synchronised level; detection is unused here
  cn_pin_sync #(
    .WIDTH (16)
  ) u_portg_sync (
    .mclk_i   (mclk_i),
    .rstn_i   (rstn_i),
    .pin_i    (portg_pin_i),
    .enable_i (16'h0000),
    .level_o  (portg_level),
    .change_o (),
    .wake_o   ()
  );

  assign cn_level_wide = CN_BITS'(cn_level);

  // next state: register writes, sticky flag, remap mux, read data
  always_comb begin
    next_q       = q;
    next_q.rdata = 16'h0000;
    stat_clear   = 1'b0;

    if (req.wr) begin
      case (req.addr)
        io_pin_config_pkg::ANSEL_ADDR: begin
          next_q.ansel = req.wdata & ANSEL_IMPL; // [R7] [R8]
        end
        io_pin_config_pkg::ANALOG_CONFIG_ADDR: begin
          next_q.vbg = req.wdata[io_pin_config_pkg::VBG_BIT]; // [R9]
        end
        io_pin_config_pkg::IRQ_STAT_ADDR: begin
          stat_clear = req.wdata[io_pin_config_pkg::IRQ_CN_BIT];
        end
        io_pin_config_pkg::IRQ_MASK_ADDR: begin
          next_q.mask = req.wdata[io_pin_config_pkg::IRQ_CN_BIT];
        end
        default: begin
        end
      endcase
      // per-pin enable and pull words; bits past the last pin stay zero
      for (int i = 0; i < CN_WORDS; i++) begin
        if (req.addr == io_pin_config_pkg::CN_EN_BASE + 8'(i)) begin
          next_q.cn_en[i*16 +: 16] = req.wdata & CN_MASK[i*16 +: 16]; // [R4] [R3]
        end
        if (req.addr == io_pin_config_pkg::PULLUP_BASE + 8'(i)) begin
          next_q.pu[i*16 +: 16] = req.wdata & CN_MASK[i*16 +: 16]; // [R5]
        end
        if (req.addr == io_pin_config_pkg::PULLDN_BASE + 8'(i)) begin
          next_q.pd[i*16 +: 16] = req.wdata & CN_MASK[i*16 +: 16]; // [R5]
        end
      end
      // each selector register feeds exactly two pins
      for (int r = 0; r < SEL_REGS; r++) begin
        if (req.addr == io_pin_config_pkg::SEL_BASE + 8'(r)) begin
          next_q.sel[2*r]   = req.wdata[io_pin_config_pkg::SEL_LO_POS +: 6]; // [R11]
          next_q.sel[2*r+1] = req.wdata[io_pin_config_pkg::SEL_HI_POS +: 6]; // [R11]
        end
      end
    end

    // a change in the clearing cycle keeps the flag set
    next_q.stat = (q.stat & ~stat_clear) | cn_change; // [R1] [R16]
    next_q.irq  = next_q.stat & next_q.mask; // [R1]

    // analog pins read back as zero on the digital path
    next_q.portg_read = portg_level & ~next_q.ansel; // [R7]

    // per-pin output selection from the peripheral output bus
    for (int p = 0; p < RP_PINS; p++) begin
      if (io_pin_config_pkg::code_routable(q.sel[p])) begin
        next_q.rp_out[p]  = periph_out_i[q.sel[p]]; // [R10] [R13]
        next_q.rp_oe_n[p] = 1'b0;
      end else begin
        next_q.rp_out[p]  = 1'b0; // [R12] [R15]
        next_q.rp_oe_n[p] = 1'b1;
      end
    end

    // read data stand only in the cycle after the strobe; unmapped reads give zero
    if (req.rd) begin
      case (req.addr)
        io_pin_config_pkg::ANSEL_ADDR: begin
          next_q.rdata = q.ansel;
        end
        io_pin_config_pkg::ANALOG_CONFIG_ADDR: begin
          next_q.rdata[io_pin_config_pkg::VBG_BIT] = q.vbg; // [R9]
        end
        io_pin_config_pkg::IRQ_STAT_ADDR: begin
          next_q.rdata[io_pin_config_pkg::IRQ_CN_BIT] = q.stat;
        end
        io_pin_config_pkg::IRQ_MASK_ADDR: begin
          next_q.rdata[io_pin_config_pkg::IRQ_CN_BIT] = q.mask;
        end
        io_pin_config_pkg::PORTG_ADDR: begin
          next_q.rdata = q.portg_read;
        end
        default: begin
        end
      endcase
      for (int i = 0; i < CN_WORDS; i++) begin
        if (req.addr == io_pin_config_pkg::CN_EN_BASE + 8'(i)) begin
          next_q.rdata = q.cn_en[i*16 +: 16];
        end
        if (req.addr == io_pin_config_pkg::PULLUP_BASE + 8'(i)) begin
          next_q.rdata = q.pu[i*16 +: 16];
        end
        if (req.addr == io_pin_config_pkg::PULLDN_BASE + 8'(i)) begin
          next_q.rdata = q.pd[i*16 +: 16];
        end
        if (req.addr == io_pin_config_pkg::CN_LVL_BASE + 8'(i)) begin
          next_q.rdata = cn_level_wide[i*16 +: 16];
        end
      end
      for (int r = 0; r < SEL_REGS; r++) begin
        if (req.addr == io_pin_config_pkg::SEL_BASE + 8'(r)) begin
          next_q.rdata = {2'b00, q.sel[2*r+1], 2'b00, q.sel[2*r]};
        end
      end
    end
  end

  // single state register; reset nulls every selector
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q <= RESET_STATE; // [R14]
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register, all but the wake request
  assign reg_rdata_o               = q.rdata;
  assign weak_pullup_o             = q.pu[CN_PINS-1:0]; // [R5]
  assign weak_pulldown_o           = q.pd[CN_PINS-1:0]; // [R5]
  assign cn_irq_o                  = q.irq;
  assign portg_read_o              = q.portg_read;
  assign portg_analog_o            = q.ansel;
  assign half_bandgap_ref_enable_o = q.vbg;
  assign remappable_pin_o          = q.rp_out;
  assign remappable_pin_oe_n_o     = q.rp_oe_n;
  // the wake request must work with the clock stopped, so it cannot be registered
  assign cn_wake_o                 = cn_wake; // [R2]

  // checks on the block's own behaviour

  property p_irq_on_change;
    @(posedge mclk_i) disable iff (!rstn_i)
      (cn_change && q.mask && !(req.wr && req.addr == io_pin_config_pkg::IRQ_MASK_ADDR))
        |=> cn_irq_o ##1 (cn_irq_o || $past(stat_clear));
  endproperty
  a_irq_on_change: assert property (p_irq_on_change) // [R1]
    else $error("change with mask set did not raise the interrupt");

  property p_flag_has_cause;
    @(posedge mclk_i) disable iff (!rstn_i)
      $rose(q.stat) |-> $past(cn_change);
  endproperty
  a_flag_has_cause: assert property (p_flag_has_cause) // [R16]
    else $error("pending flag rose without an enabled pin change");

  property p_set_beats_clear;
    @(posedge mclk_i) disable iff (!rstn_i)
      (stat_clear && cn_change) |=> q.stat;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // [R16]
    else $error("change lost in the cycle the flag was cleared");

  property p_analog_blocks_read;
    @(posedge mclk_i) disable iff (!rstn_i)
      (portg_read_o & portg_analog_o) == 16'h0000;
  endproperty
  a_analog_blocks_read: assert property (p_analog_blocks_read) // [R7]
    else $error("analog pin shows a digital read value");

  property p_pin15_absent;
    @(posedge mclk_i) disable iff (!rstn_i)
      (PKG_64 && req.rd && req.addr == io_pin_config_pkg::ANSEL_ADDR) |=> !reg_rdata_o[15];
  endproperty
  a_pin15_absent: assert property (p_pin15_absent) // [R8]
    else $error("pin 15 analog select present in the small package");

  property p_analog_config_only_bit2;
    @(posedge mclk_i) disable iff (!rstn_i)
      (req.wr && req.addr == io_pin_config_pkg::ANALOG_CONFIG_ADDR) ##1
        (req.rd && req.addr == io_pin_config_pkg::ANALOG_CONFIG_ADDR)
        |=> reg_rdata_o == {13'h0000, $past(req.wdata[2], 2), 2'b00};
  endproperty
  a_analog_config_only_bit2: assert property (p_analog_config_only_bit2) // [R9]
    else $error("analog configuration read-back wrong");

  property p_null_leaves_pin;
    @(posedge mclk_i) disable iff (!rstn_i)
      !io_pin_config_pkg::code_routable(q.sel[0])
        |=> remappable_pin_oe_n_o[0] && !remappable_pin_o[0];
  endproperty
  a_null_leaves_pin: assert property (p_null_leaves_pin) // [R12] [R15]
    else $error("null or unassigned code drove a remappable pin");

  property p_route_code;
    @(posedge mclk_i) disable iff (!rstn_i)
      io_pin_config_pkg::code_routable(q.sel[1])
        |=> !remappable_pin_oe_n_o[1]
            && remappable_pin_o[1] == $past(periph_out_i[q.sel[1]]);
  endproperty
  a_route_code: assert property (p_route_code) // [R13] [R10]
    else $error("selected peripheral output not routed to its pin");

  property p_reset_null;
    @(posedge mclk_i) disable iff (1'b0)
      !rstn_i |=> (q.sel == '0) && (&remappable_pin_oe_n_o);
  endproperty
  a_reset_null: assert property (p_reset_null) // [R14]
    else $error("selector not null after reset");

  property p_pullup_write;
    @(posedge mclk_i) disable iff (!rstn_i)
      (req.wr && req.addr == io_pin_config_pkg::PULLUP_BASE)
        |=> weak_pullup_o[15:0] == $past(req.wdata) ##1 weak_pullup_o[15:0] == $past(req.wdata, 2)
            || $past(req.wr);
  endproperty
  a_pullup_write: assert property (p_pullup_write) // [R5]
    else $error("pull-up word did not take the written value");

endmodule

/* verification/keypad_model.sv */
// behavioural push buttons to ground on the change pins, loaded by the device's weak pulls
`timescale 1ns/1ps

module keypad_model #(
  parameter int unsigned N = 18
) (
  // clock
  input  wire logic         mclk_i,
  // device pulls and button presses
  input  wire logic [N-1:0] pullup_i,
  input  wire logic [N-1:0] pulldown_i,
  input  wire logic [N-1:0] press_i,
  // pin levels
  output logic      [N-1:0] pin_o
);
  logic [N-1:0] float_lvl;

  // an undriven pin wanders, so it never settles to a level by luck
  always_ff @(posedge mclk_i) begin
    float_lvl <= ~pin_o;
  end

  // a pressed button wins over the pulls; pull-up wins over pull-down
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (press_i[i]) begin
        pin_o[i] = 1'b0;
      end else if (pullup_i[i]) begin
        pin_o[i] = 1'b1;
      end else if (pulldown_i[i]) begin
        pin_o[i] = 1'b0;
      end else begin
        pin_o[i] = (float_lvl[i] === 1'b1) ? 1'b1 : 1'b0;
      end
    end
  end
endmodule

/* verification/test_io_pin_config_remap.sv */
// self-checking bench for the pin configuration and remap block
`timescale 1ns/1ps

module test_io_pin_config_remap;
  localparam int unsigned CNP = 18;
  localparam int unsigned RPP = 4;

  logic           mclk_i;
  logic           rstn_i;
  logic [7:0]     reg_addr_i;
  logic [15:0]    reg_wdata_i;
  logic           reg_wr_i;
  logic           reg_rd_i;
  logic [15:0]    reg_rdata_o;
  logic [CNP-1:0] cn_pin_i;
  logic [CNP-1:0] weak_pullup_o;
  logic [CNP-1:0] weak_pulldown_o;
  logic [CNP-1:0] press;
  logic           cn_wake_o;
  logic           cn_irq_o;
  logic [15:0]    portg_pin_i;
  logic [15:0]    portg_read_o;
  logic [15:0]    portg_analog_o;
  logic           half_bandgap_ref_enable_o;
  logic [63:0]    periph_out_i;
  logic [RPP-1:0] remappable_pin_o;
  logic [RPP-1:0] remappable_pin_oe_n_o;
  int             num_errors;
  int             total_checks;

  io_pin_config_remap #(.CN_PINS(CNP), .RP_PINS(RPP), .PKG_64(1'b0)) i_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .cn_pin_i(cn_pin_i), .weak_pullup_o(weak_pullup_o), .weak_pulldown_o(weak_pulldown_o),
    .cn_wake_o(cn_wake_o), .cn_irq_o(cn_irq_o), .portg_pin_i(portg_pin_i),
    .portg_read_o(portg_read_o), .portg_analog_o(portg_analog_o),
    .half_bandgap_ref_enable_o(half_bandgap_ref_enable_o), .periph_out_i(periph_out_i),
    .remappable_pin_o(remappable_pin_o), .remappable_pin_oe_n_o(remappable_pin_oe_n_o));

  keypad_model #(.N(CNP)) i_keys (
    .mclk_i(mclk_i), .pullup_i(weak_pullup_o), .pulldown_i(weak_pulldown_o),
    .press_i(press), .pin_o(cn_pin_i));

  // free-running system clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // align to an edge, one write cycle, then an idle cycle so a strobe never flips twice
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
    check(d, exp);
    @(posedge mclk_i);
  endtask

  // write then read back the same word with no gap, as the port allows
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
    @(posedge mclk_i);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (cn_irq_o !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (cn_irq_o !== 1'b1) begin
      check(cn_irq_o, 1'b1);
      test_done();
    end
  endtask

  // peripheral outputs that a selector code may route
  function automatic logic routable(input int c);
    return (c >= 1 && c <= 12) || (c >= 18 && c <= 25) || (c >= 28 && c <= 31) ||
           (c >= 35 && c <= 37);
  endfunction

  // main sequence
  initial begin
    logic [5:0] cd;
    rstn_i       = 1'b0;
    reg_addr_i   = 8'h00;
    reg_wdata_i  = 16'h0000;
    reg_wr_i     = 1'b0;
    reg_rd_i     = 1'b0;
    press        = '0;
    portg_pin_i  = 16'h0000;
    periph_out_i = 64'h0;
    num_errors   = 0;
    total_checks = 0;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    check(remappable_pin_oe_n_o, 4'hF);
    check(portg_analog_o, 16'h83C0);
    check(half_bandgap_ref_enable_o, 1'b0);
    rd_chk(io_pin_config_pkg::SEL_BASE, 16'h0000);
    // port g: only bits 15 and 9:6 exist; analog pins read back zero
    portg_pin_i <= 16'hFFFF;
    wr(io_pin_config_pkg::ANSEL_ADDR, 16'hFFFF);
    rd_chk(io_pin_config_pkg::ANSEL_ADDR, 16'h83C0);
    cyc(6);
    #1;
    check(portg_read_o, 16'h7C3F);
    wr(io_pin_config_pkg::ANSEL_ADDR, 16'h0000);
    cyc(6);
    #1;
    check(portg_read_o, 16'hFFFF);
    check(portg_analog_o, 16'h0000);
    // half band-gap reference enable, other bits read zero
    wr_rd(io_pin_config_pkg::ANALOG_CONFIG_ADDR, 16'hFFFF, 16'h0004);
    #1;
    check(half_bandgap_ref_enable_o, 1'b1);
    wr(io_pin_config_pkg::ANALOG_CONFIG_ADDR, 16'h0000);
    #1;
    check(half_bandgap_ref_enable_o, 1'b0);
    // unmapped place ignores writes and reads zero
    wr(8'h08, 16'hFFFF);
    rd_chk(8'h08, 16'h0000);
    // weak pulls are separate per pin; bits past the pin count read zero
    wr(io_pin_config_pkg::PULLUP_BASE, 16'h00FF);
    wr(io_pin_config_pkg::PULLDN_BASE, 16'hFF00);
    #1;
    check(weak_pullup_o, 64'h000FF);
    check(weak_pulldown_o, 64'h0FF00);
    rd_chk(io_pin_config_pkg::PULLDN_BASE, 16'hFF00);
    wr(io_pin_config_pkg::PULLUP_BASE + 8'h01, 16'hFFFF);
    rd_chk(io_pin_config_pkg::PULLUP_BASE + 8'h01, 16'h0003);
    // all change pins are inputs here, so their pull-ups may stay on
    wr(io_pin_config_pkg::PULLUP_BASE, 16'hFFFF);
    wr(io_pin_config_pkg::PULLDN_BASE, 16'h0000);
    cyc(8);
    wr(io_pin_config_pkg::IRQ_STAT_ADDR, 16'h0001);
    wr(io_pin_config_pkg::IRQ_MASK_ADDR, 16'h0001);
    wr(io_pin_config_pkg::CN_EN_BASE, 16'h0008);
    // a disabled pin toggling raises nothing
    press[5] <= 1'b1;
    cyc(10);
    #1;
    check(cn_irq_o, 1'b0);
    check(cn_wake_o, 1'b0);
    rd_chk(io_pin_config_pkg::CN_LVL_BASE, 16'hFFDF);
    rd_chk(io_pin_config_pkg::IRQ_STAT_ADDR, 16'h0000);
    // enabled pin: wake needs no clock edge, then the interrupt follows
    press[3] <= 1'b1;
    #1;
    check(cn_wake_o, 1'b1);
    wait_irq();
    check(cn_irq_o, 1'b1);
    rd_chk(io_pin_config_pkg::IRQ_STAT_ADDR, 16'h0001);
    wr(io_pin_config_pkg::IRQ_STAT_ADDR, 16'h0001);
    #1;
    check(cn_irq_o, 1'b0);
    rd_chk(io_pin_config_pkg::IRQ_STAT_ADDR, 16'h0000);
    // masked: status still latches, the line stays low
    wr(io_pin_config_pkg::IRQ_MASK_ADDR, 16'h0000);
    press[3] <= 1'b0;
    // the clear lands in the very cycle of the change pulse; the set must win
    cyc(3);
    wr(io_pin_config_pkg::IRQ_STAT_ADDR, 16'h0001);
    cyc(10);
    #1;
    check(cn_irq_o, 1'b0);
    rd_chk(io_pin_config_pkg::IRQ_STAT_ADDR, 16'h0001);
    // every selector code on both fields of the first selector register
    for (int c = 0; c < 64; c++) begin
      cd = c[5:0];
      periph_out_i <= 64'h1 << c;
      wr(io_pin_config_pkg::SEL_BASE, {2'b00, cd, 2'b00, cd});
      cyc(2);
      #1;
      check(remappable_pin_o[1:0], routable(c) ? 2'b11 : 2'b00);
      check(remappable_pin_oe_n_o, routable(c) ? 4'hC : 4'hF);
      @(posedge mclk_i);
      periph_out_i <= ~(64'h1 << c);
      cyc(2);
      #1;
      check(remappable_pin_o[1:0], 2'b00);
      rd_chk(io_pin_config_pkg::SEL_BASE, {2'b00, cd, 2'b00, cd});
    end
    // one low field elsewhere drives only its own pin
    periph_out_i <= {64{1'b1}};
    wr(io_pin_config_pkg::SEL_BASE + 8'h01, 16'h0001);
    cyc(2);
    #1;
    check(remappable_pin_oe_n_o, 4'hB);
    check(remappable_pin_o, 4'h4);
    test_done();
  end
endmodule
